// ---- rtl/ata_pio_pkg.sv ----
// shared constants for the ata pio host cycle generator
// assumes a single 250 MHz core clock and one drive on the parallel storage bus
package ata_pio_pkg;

    // ****************************************************
    // clock and counter widths
    // ****************************************************
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned MODE_W = 3;
    localparam int unsigned NUM_MODES = 5;
    localparam logic [MODE_W-1:0] MODE_MAX = 3'h4;
    localparam int unsigned SYNC_STAGES = 2;

    // ****************************************************
    // pio timing figures in ns, modes 0 to 4
    // ****************************************************
    localparam int unsigned CYCLE_NS [NUM_MODES] = '{600, 383, 240, 180, 120};
    localparam int unsigned ACTIVE_NS [NUM_MODES] = '{165, 125, 100, 80, 70};
    localparam int unsigned RECOV_NS [NUM_MODES] = '{0, 0, 0, 70, 25};
    localparam int unsigned SETUP_NS [NUM_MODES] = '{70, 50, 30, 30, 25};
    localparam int unsigned HOLD_NS [NUM_MODES] = '{20, 15, 10, 10, 10};
    localparam int unsigned IORDY_SAMPLE_DELAY_NS = 35;

    // ****************************************************
    // address decode of the 16-bit data register
    // ****************************************************
    localparam logic [1:0] DATA_REG_CS = 2'h1;
    localparam logic [2:0] DATA_REG_DA = 3'h0;
    localparam logic [15:0] DATA_ZERO = 16'h0000;
    localparam logic [15:0] OE_ALL_OFF = 16'hffff;
    localparam logic [15:0] OE_WORD_ON = 16'h0000;
    localparam logic [15:0] OE_BYTE_ON = 16'hff00;
    localparam logic [15:0] LOW_BYTE_MASK = 16'h00ff;

    // least time in ns to whole clock cycles, rounded up, never below one
    function automatic logic [CNT_W-1:0] ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c == 0) begin
            c = 1;
        end
        return c[CNT_W-1:0];
    endfunction

    localparam logic [CNT_W-1:0] IORDY_SAMPLE_CYC = ns_to_cyc(IORDY_SAMPLE_DELAY_NS);
    localparam logic [CNT_W-1:0] IORDY_CHECK_CYC = IORDY_SAMPLE_CYC + CNT_W'(SYNC_STAGES);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETUP  = 3'h1,
        ST_STROBE = 3'h3,
        ST_WAIT   = 3'h2,
        ST_HOLD   = 3'h6
    } pio_state_t;

endpackage

// ---- rtl/pio_timing_if.sv ----
// carrier of the per-mode phase lengths between the cycle generator and its timing table
// assumes both ends run on the same core clock
`timescale 1ns/1ns
interface pio_timing_if;
    import ata_pio_pkg::*;

    logic [MODE_W-1:0] mode;
    logic [CNT_W-1:0] cycle_cyc;
    logic [CNT_W-1:0] active_cyc;
    logic [CNT_W-1:0] recov_cyc;
    logic [CNT_W-1:0] setup_cyc;
    logic [CNT_W-1:0] hold_cyc;

    modport table_end (
        input mode,
        output cycle_cyc,
        output active_cyc,
        output recov_cyc,
        output setup_cyc,
        output hold_cyc
    );

    modport user_end (
        output mode,
        input cycle_cyc,
        input active_cyc,
        input recov_cyc,
        input setup_cyc,
        input hold_cyc
    );
endinterface

// ---- rtl/pio_timing_table.sv ----
// turns a pio mode number into phase lengths in core clock cycles
// assumes the mode is steady while a cycle runs; unknown modes fall back to mode 0
`timescale 1ns/1ns
module pio_timing_table
    import ata_pio_pkg::*;
(
    pio_timing_if.table_end tim
);

    // ****************************************************
    // lookup, every figure rounded up
    // ****************************************************
    always_comb begin
        int unsigned m;
        m = (tim.mode > MODE_MAX) ? 0 : int'(tim.mode);
        tim.cycle_cyc = ns_to_cyc(CYCLE_NS[m]);
        tim.active_cyc = ns_to_cyc(ACTIVE_NS[m]);
        tim.recov_cyc = ns_to_cyc(RECOV_NS[m]);
        tim.setup_cyc = ns_to_cyc(SETUP_NS[m]);
        tim.hold_cyc = ns_to_cyc(HOLD_NS[m]);
    end

endmodule

// ---- rtl/ata_pio_host_cycle.sv ----
// ata pio host cycle generator: runs one pio read or write on the drive per request
// assumes requests come from logic on core_clk_i and the drive pins are asynchronous
`timescale 1ns/1ns
module ata_pio_host_cycle
    import ata_pio_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // configuration
    input wire logic [MODE_W-1:0] pio_mode_i,
    input wire logic rd_active_high_i,
    input wire logic wr_active_high_i,
    // request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic [1:0] req_cs_i,
    input wire logic [2:0] req_da_i,
    input wire logic req_dma_cmd_i,
    input wire logic [15:0] req_wdata_i,
    // answer
    output logic rsp_valid_o,
    output logic [15:0] rsp_rdata_o,
    // drive pins
    output logic [1:0] cs_n_o,
    output logic [2:0] da_o,
    output logic dior_o,
    output logic diow_o,
    input wire logic iordy_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic [15:0] data_oe_n_o
);

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        pio_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] cyc_cnt;
        logic [CNT_W-1:0] inact_cnt;
        logic write;
        logic wide;
        logic [15:0] wdata;
        logic [1:0] cs_n;
        logic [2:0] da;
        logic dior;
        logic diow;
        logic [15:0] dout;
        logic [15:0] oe_n;
        logic [15:0] rdata;
        logic rsp_valid;
        logic iordy_s1;
        logic iordy_s2;
        logic [15:0] data_s1;
        logic [15:0] data_s2;
    } host_state_t;

    host_state_t s;
    host_state_t next_s;

    pio_timing_if tim ();

    assign tim.mode = pio_mode_i;

    pio_timing_table u_timing (
        .tim(tim)
    );

    // true once a count plus the current cycle reaches a limit; one bit wider so a saturated count cannot wrap
    function automatic logic reached(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lim);
        return ({1'b0, v} + {{CNT_W{1'b0}}, 1'b1}) >= {1'b0, lim};
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
    endfunction

    // level driven on a strobe pin for a wanted on/off and polarity
    function automatic logic strobe_level(input logic on, input logic active_high);
        return on ? active_high : ~active_high;
    endfunction

    localparam host_state_t RESET_STATE = '{
        st: ST_IDLE,
        cnt: '0,
        cyc_cnt: '1,
        inact_cnt: '1,
        write: 1'b0,
        wide: 1'b0,
        wdata: DATA_ZERO,
        cs_n: 2'h3,
        da: 3'h0,
        dior: 1'b1,
        diow: 1'b1,
        dout: DATA_ZERO,
        oe_n: OE_ALL_OFF,
        rdata: DATA_ZERO,
        rsp_valid: 1'b0,
        iordy_s1: 1'b1,
        iordy_s2: 1'b1,
        data_s1: DATA_ZERO,
        data_s2: DATA_ZERO
    };

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        logic strobe_on;
        logic release_now;
        logic gate_ok;
        strobe_on = 1'b0;
        release_now = 1'b0;
        gate_ok = 1'b0;
        next_s = s;
        next_s.rsp_valid = 1'b0;
        next_s.cnt = sat_inc(s.cnt);
        next_s.cyc_cnt = sat_inc(s.cyc_cnt);
        next_s.inact_cnt = sat_inc(s.inact_cnt);

        // pin synchronisers
        next_s.iordy_s1 = iordy_i;
        next_s.iordy_s2 = s.iordy_s1;
        next_s.data_s1 = data_i;
        next_s.data_s2 = s.data_s1;

        // strobe may rise only once the previous cycle and recovery are long enough
        gate_ok = reached(s.cyc_cnt, tim.cycle_cyc)
                && reached(s.inact_cnt, tim.recov_cyc);

        unique case (s.st)
            ST_IDLE: begin
                if (req_valid_i) begin
                    next_s.st = ST_SETUP;
                    next_s.cnt = '0;
                    next_s.write = req_write_i;
                    next_s.wdata = req_wdata_i;
                    next_s.cs_n = ~req_cs_i;
                    next_s.da = req_da_i;
                    next_s.wide = req_dma_cmd_i
                        || (req_cs_i == DATA_REG_CS && req_da_i == DATA_REG_DA);
                    if (req_write_i) begin
                        next_s.dout = req_wdata_i;
                        next_s.oe_n = (next_s.wide) ? OE_WORD_ON : OE_BYTE_ON;
                    end
                end
            end
            ST_SETUP: begin
                if (reached(s.cnt, tim.setup_cyc) && gate_ok) begin
                    next_s.st = ST_STROBE;
                    next_s.cnt = '0;
                    next_s.cyc_cnt = '0;
                    strobe_on = 1'b1;
                end
            end
            ST_STROBE: begin
                strobe_on = 1'b1;
                // synchronised iordy at this count reflects the pin at the sample delay
                if (s.cnt == IORDY_CHECK_CYC && !s.iordy_s2) begin
                    next_s.st = ST_WAIT;
                end else if (s.cnt > IORDY_CHECK_CYC && reached(s.cnt, tim.active_cyc)) begin
                    release_now = 1'b1;
                end
            end
            ST_WAIT: begin
                strobe_on = 1'b1;
                if (s.iordy_s2 && reached(s.cnt, tim.active_cyc)) begin
                    release_now = 1'b1;
                end
            end
            ST_HOLD: begin
                if (reached(s.cnt, tim.hold_cyc)) begin
                    next_s.st = ST_IDLE;
                    next_s.cs_n = 2'h3;
                    next_s.oe_n = OE_ALL_OFF;
                    next_s.rsp_valid = 1'b1;
                end
            end
            default: begin
                next_s = RESET_STATE;
            end
        endcase

        if (release_now) begin
            strobe_on = 1'b0;
            next_s.st = ST_HOLD;
            next_s.cnt = '0;
            next_s.inact_cnt = '0;
            if (!s.write) begin
                next_s.rdata = s.wide ? s.data_s2 : (s.data_s2 & LOW_BYTE_MASK);
            end
        end

        next_s.dior = strobe_level(strobe_on && !s.write, rd_active_high_i);
        next_s.diow = strobe_level(strobe_on && s.write, wr_active_high_i);
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign req_ready_o = (s.st == ST_IDLE);
    assign rsp_valid_o = s.rsp_valid;
    assign rsp_rdata_o = s.rdata;
    assign cs_n_o = s.cs_n;
    assign da_o = s.da;
    assign dior_o = s.dior;
    assign diow_o = s.diow;
    assign data_o = s.dout;
    assign data_oe_n_o = s.oe_n;

endmodule

// ---- test/ata_pio_props.sv ----
// checker of pin timing for the pio host cycle generator
// assumes a bind to the top module; strobe polarity changes only while idle and is 0 across reset
`timescale 1ns/1ns
module ata_pio_props
    import ata_pio_pkg::*;
(
    // clock, reset and settings
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [MODE_W-1:0] pio_mode_i,
    input wire logic rd_active_high_i,
    input wire logic wr_active_high_i,
    // request side
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic req_write_i,
    input wire logic [1:0] req_cs_i,
    input wire logic [2:0] req_da_i,
    input wire logic req_dma_cmd_i,
    // drive pins
    input wire logic [1:0] cs_n_o,
    input wire logic [2:0] da_o,
    input wire logic dior_o,
    input wire logic diow_o,
    input wire logic iordy_i,
    input wire logic [15:0] data_oe_n_o
);
    logic rd_pol, wr_pol, was_on;
    logic [7:0] since_on, since_off;
    int m, act_min, cyc_min, rec_min;
    wire logic on = (dior_o == rd_pol) || (diow_o == wr_pol);
    wire logic wide = req_dma_cmd_i || (req_cs_i == DATA_REG_CS && req_da_i == DATA_REG_DA);
    wire logic take = req_valid_i && req_ready_o;

    always_comb begin
        m = (pio_mode_i > MODE_MAX) ? 0 : int'(pio_mode_i);
        act_min = (ACTIVE_NS[m] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        cyc_min = (CYCLE_NS[m] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        rec_min = (RECOV_NS[m] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    end

    // cycles since the strobe was last seen to rise and to fall
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_pol <= 1'b0;
            wr_pol <= 1'b0;
            was_on <= 1'b0;
            since_on <= 8'hff;
            since_off <= 8'hff;
        end else begin
            rd_pol <= rd_active_high_i;
            wr_pol <= wr_active_high_i;
            was_on <= on;
            since_on <= (on && !was_on) ? 8'h01 : since_on + 8'(since_on != 8'hff);
            since_off <= (!on && was_on) ? 8'h01 : since_off + 8'(since_off != 8'hff);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_rise; on && !was_on; endsequence
    sequence s_fall; !on && was_on; endsequence

    property p_addr; take |=> cs_n_o == ~$past(req_cs_i) && da_o == $past(req_da_i); endproperty
    a_addr: assert property (p_addr) else $error("address not taken from request");
    property p_byte; take && req_write_i && !wide |=> data_oe_n_o == OE_BYTE_ON; endproperty
    a_byte: assert property (p_byte) else $error("byte write enables wrong");
    property p_word; take && req_write_i && wide |=> data_oe_n_o == OE_WORD_ON; endproperty
    a_word: assert property (p_word) else $error("word write enables wrong");
    property p_hold; on |-> $stable(cs_n_o) && $stable(da_o); endproperty
    a_hold: assert property (p_hold) else $error("address moved under strobe");
    property p_active; s_fall |-> since_on >= act_min; endproperty
    a_active: assert property (p_active) else $error("strobe too short");
    property p_cycle; s_rise |-> since_on >= cyc_min && since_off >= rec_min; endproperty
    a_cycle: assert property (p_cycle) else $error("cycle or recovery too short");
    property p_release; on && $rose(iordy_i) && since_on > act_min |-> ##[1:4] !on; endproperty
    a_release: assert property (p_release) else $error("strobe not ended after ready");
    property p_idle; req_ready_o |-> cs_n_o == 2'h3 && data_oe_n_o == OE_ALL_OFF && !on; endproperty
    a_idle: assert property (p_idle) else $error("bus not released in idle");
endmodule

// ---- test/ata_drive_model.sv ----
// behavioural drive: serves a read word, records written data, can hold iordy low
// assumes strobe polarity comes from the bench and the low window stays short
`timescale 1ns/1ns
module ata_drive_model (
    // host pins and bench controls
    input wire logic clk_i,
    input wire logic rd_pol_i,
    input wire logic wr_pol_i,
    input wire logic dior_i,
    input wire logic diow_i,
    input wire logic [15:0] bus_i,
    input wire logic [15:0] oe_n_i,
    input wire logic [15:0] rd_word_i,
    input wire logic [8:0] lo_start_i,
    input wire logic [8:0] lo_len_i,
    // drive side
    output logic iordy_o,
    output logic [15:0] data_o,
    output logic [15:0] wr_seen_o
);
    logic [8:0] cnt = 9'h0;
    wire logic rd_on = dior_i == rd_pol_i;
    wire logic on = rd_on || (diow_i == wr_pol_i);
    always @(posedge clk_i) begin
        cnt <= on ? cnt + 9'h1 : 9'h0;
        if (on && oe_n_i != 16'hffff) begin
            wr_seen_o <= bus_i & ~oe_n_i;
        end
    end
    // pulled up outside the low window, which the bench keeps short
    assign iordy_o = !(on && cnt >= lo_start_i && cnt < lo_start_i + lo_len_i);
    // read word valid before the window ends, inverse when released
    assign data_o = (rd_on && cnt + 9'h1 >= lo_start_i + lo_len_i) ? rd_word_i : ~rd_word_i;
endmodule

// ---- test/testbench.sv ----
// self-checking bench of the pio host cycle generator against a behavioural drive
// assumes package, design, checker and drive model are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("Error %0t got %h exp %h", $time, a, b); end end
module testbench import ata_pio_pkg::*;;
    typedef struct packed {logic [2:0] mode; logic wr; logic [1:0] cs; logic [2:0] da; logic dma; logic [15:0] d;} row_t;
    logic core_clk_i = 0, resetn_i = 0, rd_active_high_i = 0, wr_active_high_i = 0;
    logic req_valid_i = 0, req_write_i = 0, req_dma_cmd_i = 0, req_ready_o, rsp_valid_o, dior_o, diow_o, iordy_i;
    logic [2:0] pio_mode_i = 3'h4, req_da_i = 3'h0, da_o;
    logic [1:0] req_cs_i = 2'h0, cs_n_o;
    logic [15:0] req_wdata_i = 16'h0000, rd_word = 16'h0000, rsp_rdata_o, data_o, data_oe_n_o, drv, wr_seen, data_i;
    logic [8:0] lo_start = 9'h0, lo_len = 9'h0;
    int fails = 0, checks = 0, len;
    row_t rows [7] = '{'{3'h4, 1'b0, 2'h1, 3'h7, 1'b0, 16'ha5c3}, '{3'h4, 1'b0, 2'h1, 3'h0, 1'b0, 16'h1234},
        '{3'h3, 1'b1, 2'h1, 3'h3, 1'b0, 16'hbeef}, '{3'h2, 1'b1, 2'h2, 3'h6, 1'b1, 16'hcafe},
        '{3'h1, 1'b0, 2'h2, 3'h6, 1'b1, 16'h8001}, '{3'h0, 1'b1, 2'h1, 3'h0, 1'b0, 16'h7e81},
        '{3'h5, 1'b0, 2'h2, 3'h1, 1'b0, 16'h0ff0}};
    assign data_i = (data_o & ~data_oe_n_o) | (drv & data_oe_n_o);

    ata_pio_host_cycle dut (.core_clk_i, .resetn_i, .pio_mode_i, .rd_active_high_i, .wr_active_high_i,
        .req_valid_i, .req_ready_o, .req_write_i, .req_cs_i, .req_da_i, .req_dma_cmd_i, .req_wdata_i,
        .rsp_valid_o, .rsp_rdata_o, .cs_n_o, .da_o, .dior_o, .diow_o, .iordy_i, .data_i, .data_o, .data_oe_n_o);
    ata_drive_model drive (.clk_i(core_clk_i), .rd_pol_i(rd_active_high_i), .wr_pol_i(wr_active_high_i),
        .dior_i(dior_o), .diow_i(diow_o), .bus_i(data_o), .oe_n_i(data_oe_n_o), .rd_word_i(rd_word),
        .lo_start_i(lo_start), .lo_len_i(lo_len), .iordy_o(iordy_i), .data_o(drv), .wr_seen_o(wr_seen));

    function automatic int act(input logic [2:0] m);
        int k;
        k = (m > 3'h4) ? 0 : int'(m);
        return (ACTIVE_NS[k] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction

    function automatic logic [15:0] exp16(input row_t r);
        return (r.dma || (r.cs == 2'h1 && r.da == 3'h0)) ? r.d : r.d & LOW_BYTE_MASK;
    endfunction

    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one pio cycle; len counts the cycles the strobe stood active
    task automatic run(input row_t r);
        int n;
        n = 0;
        len = 0;
        @(negedge core_clk_i);
        {pio_mode_i, req_write_i, req_cs_i, req_da_i, req_dma_cmd_i, req_wdata_i} = r;
        rd_word = r.d;
        req_valid_i = 1'b1;
        while (!req_ready_o && n < 400) begin
            @(negedge core_clk_i);
            n++;
        end
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        while (rsp_valid_o !== 1'b1 && n < 2000) begin
            len += int'((dior_o == rd_active_high_i) || (diow_o == wr_active_high_i));
            @(negedge core_clk_i);
            n++;
        end
        `CHK(rsp_valid_o, 1'b1)
    endtask

    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    initial begin
        #100000;
        fails++;
        final_report();
    end

    initial begin
        repeat (2) @(negedge core_clk_i);
        resetn_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd_active_high_i = i[0];
            wr_active_high_i = i[0];
            run(rows[i]);
            `CHK(rows[i].wr ? wr_seen : rsp_rdata_o, exp16(rows[i]))
            `CHK(len, act(rows[i].mode))
            `CHK({dior_o, diow_o}, {~rd_active_high_i, ~wr_active_high_i})
            $display("row %0d done", i);
        end
        lo_start = 9'h2;
        lo_len = 9'h3c;
        run(row_t'{3'h4, 1'b0, 2'h1, 3'h0, 1'b0, 16'h5aa5});
        `CHK(len inside {[62:67]}, 1'b1)
        `CHK(rsp_rdata_o, 16'h5aa5)
        $display("wait state test done");
        lo_start = 9'h1;
        lo_len = 9'h4;
        run(row_t'{3'h4, 1'b1, 2'h1, 3'h0, 1'b0, 16'h3cc3});
        `CHK(len, act(3'h4))
        $display("short low pulse test done");
        lo_len = 9'h0;
        req_valid_i = 1'b1;
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        repeat (12) @(negedge core_clk_i);
        resetn_i = 1'b0;
        @(negedge core_clk_i);
        `CHK({req_ready_o, rsp_valid_o, cs_n_o, data_oe_n_o, dior_o}, {1'b1, 1'b0, 2'h3, OE_ALL_OFF, 1'b1})
        resetn_i = 1'b1;
        run(rows[1]);
        `CHK(rsp_rdata_o, 16'h1234)
        $display("reset test done");
        final_report();
    end
endmodule

bind ata_pio_host_cycle ata_pio_props props (.core_clk_i, .resetn_i, .pio_mode_i, .rd_active_high_i,
    .wr_active_high_i, .req_valid_i, .req_ready_o, .req_write_i, .req_cs_i, .req_da_i, .req_dma_cmd_i,
    .cs_n_o, .da_o, .dior_o, .diow_o, .iordy_i, .data_oe_n_o);
